/* inc/smc_consts.vh */
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH
`define SMC_ADDR_W 2
`define SMC_OFS_SYSCTL 2'h0
`define SMC_OFS_MSTOP1 2'h1
`define SMC_OFS_MSTOP2 2'h2
`define SMC_OFS_STATUS 2'h3
`define SMC_SYSCTL_FIX 8'hC0
`define SMC_SYSCTL_RW 8'h03
`define SMC_SYSCTL_RST 8'h01
`define SMC_BIT_RAM_EN 0
`define SMC_BIT_TDBG_RST 1
`define SMC_MSTOP1_FIX 16'hF010
`define SMC_MSTOP1_RW 16'h0F2F
`define SMC_MSTOP1_RST 16'h002F
`define SMC_MSTOP2_FIX 16'hC0C0
`define SMC_MSTOP2_RW 16'h303D
`define SMC_MSTOP2_RST 16'h3030
`define SMC_MSTOP2_DBG 16'h000C
`define SMC_BIT_RAM_STOP 11
`define SMC_BIT_ROM_STOP 10
`define SMC_BIT_XFER_STOP 9
`define SMC_BIT_DMA_STOP 8
`define SMC_BIT_I2C_STOP 5
`define SMC_BIT_SER3_STOP 3
`define SMC_BIT_SER2_STOP 2
`define SMC_BIT_SER1_STOP 1
`define SMC_BIT_SER0_STOP 0
`define SMC_BIT_PTMR_STOP 13
`define SMC_BIT_MTMR_STOP 12
`define SMC_BIT_ADC1_STOP 5
`define SMC_BIT_ADC0_STOP 4
`define SMC_BIT_TDBG_STOP 3
`define SMC_BIT_DPORT_STOP 2
`define SMC_BIT_BRK_STOP 0
`endif

/* src/smc_sync2.v */
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a pin level
module smc_sync2 (
  input wire ref_clk_i,
  input wire rst_i,
  input wire d_i,
  output reg q_o
);
  reg meta;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

/* src/smc_top.v */
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.vh"
// How it works
// - soft reset bit 1 at 0 holds trace debug in reset
// - ram enable 0 gates ram access
// - standby bit 1 stops its module
// - first standby register reset values
// - second standby register reset values
// - emulator mode: trace debug and debug port keep running, break control can still stop
// - reserved bits read fixed values
// - stop changes at bus cycle end
// - stopped modules ignore register access
module smc_top (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [`SMC_ADDR_W-1:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire bus_busy_i,
  input wire debug_mode_pin_i,
  output reg [15:0] rdata_o,
  output reg trace_debug_reset_o,
  output reg ram_access_enable_o,
  output reg [15:0] stop_1_o,
  output reg [15:0] stop_2_o,
  output reg [15:0] reg_block_1_o,
  output reg [15:0] reg_block_2_o
);
  reg [7:0] system_control;
  reg [15:0] module_stop_control_1;
  reg [15:0] module_stop_control_2;
  reg [7:0] next_system_control;
  reg [15:0] next_module_stop_control_1;
  reg [15:0] next_module_stop_control_2;
  reg [15:0] next_rdata;
  wire emu_mode;
  wire wr_sysctl;
  wire wr_mstop1;
  wire wr_mstop2;
  wire trace_debug_soft_reset;
  wire ram_access_enable;
  wire ram_stop;
  wire rom_stop;
  wire transfer_ctl_stop;
  wire dma_stop;
  wire i2c_stop;
  wire serial3_stop;
  wire serial2_stop;
  wire serial1_stop;
  wire serial0_stop;
  wire pulse_timer_stop;
  wire match_timer_stop;
  wire adc1_stop;
  wire adc0_stop;
  wire trace_debug_stop;
  wire debug_port_stop;
  wire break_ctl_stop;
  wire [15:0] next_stop_1;
  wire [15:0] next_stop_2;

  // debug mode pin is asynchronous
  smc_sync2 u_dbg_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(debug_mode_pin_i),
    .q_o(emu_mode)
  );

  function is_index;
    input [`SMC_ADDR_W-1:0] idx;
    input [`SMC_ADDR_W-1:0] ofs;
    begin
      is_index = (idx == ofs);
    end
  endfunction

  function [7:0] merge8;
    input [7:0] wd;
    input [7:0] rw;
    input [7:0] fix;
    begin
      merge8 = (wd & rw) | fix;
    end
  endfunction

  function [15:0] merge16;
    input [15:0] wd;
    input [15:0] rw;
    input [15:0] fix;
    begin
      merge16 = (wd & rw) | fix;
    end
  endfunction

  // register write decode
  assign wr_sysctl = wr_i & is_index(addr_i, `SMC_OFS_SYSCTL);
  assign wr_mstop1 = wr_i & is_index(addr_i, `SMC_OFS_MSTOP1);
  assign wr_mstop2 = wr_i & is_index(addr_i, `SMC_OFS_MSTOP2);

  always @* begin
    next_system_control = system_control;
    next_module_stop_control_1 = module_stop_control_1;
    next_module_stop_control_2 = module_stop_control_2;
    if (wr_sysctl) begin
      next_system_control = merge8(wdata_i[7:0], `SMC_SYSCTL_RW, `SMC_SYSCTL_FIX);
    end
    if (wr_mstop1) begin
      next_module_stop_control_1 = merge16(wdata_i, `SMC_MSTOP1_RW, `SMC_MSTOP1_FIX);
    end
    if (wr_mstop2) begin
      next_module_stop_control_2 = merge16(wdata_i, `SMC_MSTOP2_RW, `SMC_MSTOP2_FIX);
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      system_control <= `SMC_SYSCTL_FIX | `SMC_SYSCTL_RST;
      module_stop_control_1 <= `SMC_MSTOP1_FIX | `SMC_MSTOP1_RST;
      module_stop_control_2 <= `SMC_MSTOP2_FIX | `SMC_MSTOP2_RST;
    end else begin
      system_control <= next_system_control;
      module_stop_control_1 <= next_module_stop_control_1;
      module_stop_control_2 <= next_module_stop_control_2;
    end
  end

  // system control fields
  assign trace_debug_soft_reset = system_control[`SMC_BIT_TDBG_RST];
  assign ram_access_enable = system_control[`SMC_BIT_RAM_EN];

  // first standby register, per module
  assign ram_stop = module_stop_control_1[`SMC_BIT_RAM_STOP];
  assign rom_stop = module_stop_control_1[`SMC_BIT_ROM_STOP];
  // bits 9,8 kept apart, software pairs them
  assign transfer_ctl_stop = module_stop_control_1[`SMC_BIT_XFER_STOP];
  assign dma_stop = module_stop_control_1[`SMC_BIT_DMA_STOP];
  assign i2c_stop = module_stop_control_1[`SMC_BIT_I2C_STOP];
  assign serial3_stop = module_stop_control_1[`SMC_BIT_SER3_STOP];
  assign serial2_stop = module_stop_control_1[`SMC_BIT_SER2_STOP];
  assign serial1_stop = module_stop_control_1[`SMC_BIT_SER1_STOP];
  assign serial0_stop = module_stop_control_1[`SMC_BIT_SER0_STOP];

  // second standby register, per module
  assign pulse_timer_stop = module_stop_control_2[`SMC_BIT_PTMR_STOP];
  assign match_timer_stop = module_stop_control_2[`SMC_BIT_MTMR_STOP];
  assign adc1_stop = module_stop_control_2[`SMC_BIT_ADC1_STOP];
  assign adc0_stop = module_stop_control_2[`SMC_BIT_ADC0_STOP];
  // trace debug and debug port run in emulator mode; break control does not
  assign trace_debug_stop = module_stop_control_2[`SMC_BIT_TDBG_STOP] & ~emu_mode;
  assign debug_port_stop = module_stop_control_2[`SMC_BIT_DPORT_STOP] & ~emu_mode;
  assign break_ctl_stop = module_stop_control_2[`SMC_BIT_BRK_STOP];

  // reserved positions never request a stop
  assign next_stop_1 = {
    4'h0,
    ram_stop,
    rom_stop,
    transfer_ctl_stop,
    dma_stop,
    2'b00,
    i2c_stop,
    1'b0,
    serial3_stop,
    serial2_stop,
    serial1_stop,
    serial0_stop
  };

  assign next_stop_2 = {
    2'b00,
    pulse_timer_stop,
    match_timer_stop,
    4'h0,
    2'b00,
    adc1_stop,
    adc0_stop,
    trace_debug_stop,
    debug_port_stop,
    1'b0,
    break_ctl_stop
  };

  // read data only in the cycle after a read
  always @* begin
    next_rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        `SMC_OFS_SYSCTL: next_rdata = {8'h00, system_control};
        `SMC_OFS_MSTOP1: next_rdata = module_stop_control_1;
        `SMC_OFS_MSTOP2: next_rdata = module_stop_control_2;
        `SMC_OFS_STATUS: next_rdata = {15'h0000, emu_mode};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
      trace_debug_reset_o <= 1'b1;
      ram_access_enable_o <= 1'b1;
      stop_1_o <= `SMC_MSTOP1_RW & `SMC_MSTOP1_RST;
      stop_2_o <= `SMC_MSTOP2_RW & `SMC_MSTOP2_RST;
      reg_block_1_o <= `SMC_MSTOP1_RW & `SMC_MSTOP1_RST;
      reg_block_2_o <= `SMC_MSTOP2_RW & `SMC_MSTOP2_RST;
    end else begin
      rdata_o <= next_rdata;
      trace_debug_reset_o <= ~trace_debug_soft_reset;
      ram_access_enable_o <= ram_access_enable;
      if (!bus_busy_i) begin
        stop_1_o <= next_stop_1;
        stop_2_o <= next_stop_2;
        reg_block_1_o <= next_stop_1;
        reg_block_2_o <= next_stop_2;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/smc_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_chk (
  input wire logic ref_clk_i, rst_i, wr_i, rd_i, bus_busy_i, ram_access_enable_o,
  input wire logic trace_debug_reset_o,
  input wire logic [1:0] addr_i,
  input wire logic [15:0] wdata_i, rdata_o, stop_1_o, stop_2_o, reg_block_1_o, reg_block_2_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_rd; rd_i && !addr_i |=> rdata_o[15:2] == 14'h30; endproperty
  a_rd: assert property (p_rd) else $error("ctl read");
  property p_ram; wr_i && !addr_i |-> ##2 ram_access_enable_o == $past(wdata_i[0], 2); endproperty
  a_ram: assert property (p_ram) else $error("ram enable");
  property p_bsy; bus_busy_i |=> $stable(stop_1_o); endproperty
  a_bsy: assert property (p_bsy) else $error("stop moved");
  property p_st; wr_i && addr_i == 2'h1 ##1 !bus_busy_i
    |=> stop_1_o == ($past(wdata_i, 2) & 16'h0F2F); endproperty
  a_st: assert property (p_st) else $error("stop value");
  property p_rst; $fell(rst_i) |-> stop_1_o == 16'h002F && stop_2_o == 16'h3030; endproperty
  a_rst: assert property (p_rst) else $error("stop reset");
  property p_tdr; wr_i && !addr_i |-> ##2 trace_debug_reset_o == !$past(wdata_i[1], 2); endproperty
  a_tdr: assert property (p_tdr) else $error("trace reset");
  property p_blk; reg_block_1_o == stop_1_o && reg_block_2_o == stop_2_o; endproperty
  a_blk: assert property (p_blk) else $error("block mismatch");
  property p_rsv; (stop_1_o & 16'hF0D0) == 16'h0 && (stop_2_o & 16'hCFC2) == 16'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved stop");
  cover property (rd_i);
  cover property (wr_i ##1 bus_busy_i);
  cover property (wr_i && addr_i == 2'h1);
endmodule
bind smc_top smc_chk u_chk (.*);
`default_nettype wire

/* tb/system_and_module_stop_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module system_and_module_stop_control_tb;
  logic ref_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, bus_busy_i = 0, debug_mode_pin_i = 0;
  logic trace_debug_reset_o, ram_access_enable_o, p;
  logic [1:0] addr_i = 0, a;
  logic [15:0] wdata_i = 0, d, rdata_o, stop_1_o, stop_2_o, reg_block_1_o, reg_block_2_o;
  logic [15:0] rw [4] = '{16'h0003, 16'h0F2F, 16'h303D, 16'h0000};
  logic [15:0] m [4] = '{16'h00C1, 16'hF03F, 16'hF0F0, 16'h0000};
  int n_mismatch = 0, num_checks = 0;
  smc_top dut (.*);
  always #2.5 ref_clk_i = ~ref_clk_i;
  task chk(input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task final_report;
    $display("%0d checks, %0d mismatches", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #5000 n_mismatch++;
    final_report;
  end
  initial begin
    void'($urandom(17433));
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 0;
    repeat (30) begin
      for (int i = 0; i < 4; i++) begin
        @(posedge ref_clk_i);
        {addr_i, rd_i, bus_busy_i} <= {2'(i), 2'b10};
        @(posedge ref_clk_i);
        rd_i <= 0;
        #1 chk(rdata_o, m[i]);
      end
      chk(stop_1_o, m[1] & rw[1]);
      chk(reg_block_1_o, m[1] & rw[1]);
      chk(stop_2_o, m[2] & rw[2] & ~(m[3][0] ? 16'h000C : 16'h0000));
      chk(reg_block_2_o, m[2] & rw[2] & ~(m[3][0] ? 16'h000C : 16'h0000));
      chk({!trace_debug_reset_o, ram_access_enable_o}, m[0][1:0]);
      a = 2'($urandom);
      d = 16'($urandom) & rw[a] | m[a] & ~rw[a];
      d[9] = d[8];
      p = 1'($urandom);
      @(posedge ref_clk_i);
      // next access after any write is a control read
      {addr_i, wdata_i, wr_i, bus_busy_i} <= {a, d, 1'b1, 1'($urandom)};
      debug_mode_pin_i <= p;
      @(posedge ref_clk_i);
      wr_i <= 0;
      m[a] = d;
      m[3] = {15'h0000, p};
      $display("round done");
    end
    final_report;
  end
endmodule
`default_nettype wire
